// File: adc_sync_defines.svh
// Register map, field positions, reset values and counts of the ADC sync block
`ifndef ADC_SYNC_DEFINES_SVH
`define ADC_SYNC_DEFINES_SVH
`define OFS_CTRL 8'h00
`define OFS_PHASE 8'h04
`define OFS_CAL 8'h08
`define OFS_STAT 8'h0C
`define OFS_DIVA 8'h10
`define OFS_DIVB 8'h14
`define OFS_DATA 8'h20
`define CTRL_RST 16'h0C00
`define PHASE_RST 7'h00
`define CAL_RST 5'h00
`define DIV_RST 6'h06
`define B_EXT_A 0
`define B_EXT_B 1
`define B_RD_A 2
`define B_RD_B 3
`define B_MUX 4
`define B_SYNC_A 7
`define B_SYNC_B 8
`define B_STAT_SEL 9
`define DIV_LSB 6
`define SLICES 8'h80
`define SETTLE_PERIODS 3'h4
`define VEC_A 16'h0030
`define VEC_B 16'h0038
`define VEC_NONE 16'h0000
`endif

// File: adc_sync_pkg.sv
// Types shared by the ADC sync block
package adc_sync_pkg;
   typedef logic [15:0] sample_t;
   typedef struct packed {
      logic [15:0] ctrl;
      logic [6:0] phase;
      logic [4:0] cal;
      logic [5:0] diva;
      logic [5:0] divb;
      logic wp;
      logic [7:0] wa;
      logic [31:0] hrdata;
      logic [11:0] cnt_a;
      logic [11:0] cnt_b;
      logic m1;
      logic m2;
      logic m3;
      logic t1;
      logic t2;
      logic t3;
      logic d1;
      logic d2;
      logic rd;
      logic upd_a;
      logic upd_b;
      logic irq_a;
      logic irq_b;
      logic [15:0] vec;
      logic [2:0] settle;
      logic [4:0][15:0] data;
   } state_t;
endpackage

// File: adc_sync_ctrl.sv
// ADC bank update timing, PWM alignment, calibration and settle control
`timescale 1ns/10ps
`include "adc_sync_defines.svh"

module adc_sync_ctrl
   import adc_sync_pkg::*;
(
   input wire logic hclk, // Input clock
   input wire logic hresetn, // Async reset, low
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Byte address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write access
   input wire logic [2:0] hsize, // Word only
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready, // Bus ready
   output logic hreadyout, // Always ready
   output logic hresp, // Always OKAY
   output logic [31:0] hrdata, // Read data
   input wire logic pwm_period_marker, // PWM marker pin
   input wire logic pwm_double_update, // PWM double mode
   input wire logic conversion_trigger, // External start pin
   input wire sample_t filt_data [5], // Filter results
   output logic [2:0] expansion_select, // Mux select pins
   output logic [4:0] cal_tie_ref, // Inputs to reference
   output logic bank_a_update, // Bank A latch pulse
   output logic bank_b_update, // Bank B latch pulse
   output logic bank_a_irq, // Bank A interrupt
   output logic bank_b_irq, // Bank B interrupt
   output logic [15:0] irq_vector // Top pending vector
);

   state_t s;
   state_t n;
   logic acc;
   logic marker;
   logic trig;
   logic [6:0] eoff;
   logic lagz;
   logic [11:0] per_a;
   logic [11:0] per_b;
   logic [12:0] st_a;
   logic [12:0] st_b;
   logic fire_a;
   logic fire_b;
   logic upd_a;
   logic upd_b;
   logic wr;
   logic load;
   logic mon_tick;

   ////////////////////////////////////////////////////////////////////
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction

   function automatic logic [11:0] clamp(input logic [11:0] v);
      return (v == 12'h000) ? 12'h001 : v;
   endfunction

   // Lag in clocks: (128 - offset) slices of field*64/128 clocks
   function automatic logic [11:0] lag(input logic [6:0] off,
                                       input logic [5:0] fld);
      logic [13:0] p;
      p = 14'((`SLICES - {1'b0, off}) * fld);
      return clamp(p[12:1]);
   endfunction

   // Divider step; restart on marker, fire at count zero
   function automatic logic [12:0] step(input logic [11:0] cnt,
                                        input logic [11:0] per,
                                        input logic restart,
                                        input logic zero_lag,
                                        input logic [11:0] lg);
      logic [11:0] p1;
      p1 = clamp(per) - 12'h001;
      if (restart && zero_lag) begin
         return {1'b1, p1};
      end else if (restart) begin
         return {1'b0, lg - 12'h001};
      end else if (cnt == 12'h000) begin
         return {1'b1, p1};
      end
      return {1'b0, cnt - 12'h001};
   endfunction

   function automatic logic [31:0] rd_word(input state_t q,
                                           input logic [7:0] a);
      logic [31:0] w;
      w = 32'h00000000;
      if (hit(a, `OFS_CTRL)) begin
         w = {16'h0000, q.ctrl};
      end else if (hit(a, `OFS_PHASE)) begin
         w = {25'h0000000, q.phase};
      end else if (hit(a, `OFS_CAL)) begin
         w = {27'h0000000, q.cal};
      end else if (hit(a, `OFS_STAT)) begin
         w = {31'h00000000, q.settle != 3'h0};
      end else if (hit(a, `OFS_DIVA)) begin
         w = {20'h00000, q.diva, 6'h00};
      end else if (hit(a, `OFS_DIVB)) begin
         w = {20'h00000, q.divb, 6'h00};
      end else begin
         for (int i = 0; i < 5; i++) begin
            if (hit(a, 8'(`OFS_DATA + 4 * i))) begin
               w = {q.data[i], 16'h0000};
            end
         end
      end
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////
   assign acc = hsel & htrans[1] & hready;
   assign wr = s.wp;
   // marker may pulse at midpoint too; both restart
   assign marker = s.m2 & ~s.m3;
   assign trig = s.t2 & ~s.t3;
   // offset ignored in double update mode
   assign eoff = s.d2 ? 7'h00 : s.phase;
   assign lagz = eoff == 7'h00;
   // only bits 6 to 11 of the divider count
   assign per_a = {s.diva, 6'h00};
   assign per_b = {s.divb, 6'h00};
   // bank A restarts on marker when locked
   // divider restart keeps fixed phase to marker
   // offset applied in 128ths of the update period
   // lag of 128 minus offset slices
   // same fraction at any ADC to PWM ratio
   assign st_a = step(s.cnt_a, per_a, s.ctrl[`B_SYNC_A] & marker, lagz,
                      lag(eoff, s.diva));
   // bank B restarts on marker when locked
   assign st_b = step(s.cnt_b, per_b, s.ctrl[`B_SYNC_B] & marker, lagz,
                      lag(eoff, s.divb));
   // zero offset fires on the marker itself
   // multiples realign at every period start
   assign fire_a = st_a[12];
   assign fire_b = st_b[12];

   // synchronized trigger edge when external selected
   assign upd_a = s.ctrl[`B_RD_A] ? s.rd :
                  s.ctrl[`B_EXT_A] ? trig : fire_a;
   assign upd_b = s.ctrl[`B_RD_B] ? s.rd :
                  s.ctrl[`B_EXT_B] ? trig : fire_b;

   assign mon_tick = s.ctrl[`B_STAT_SEL] ? fire_b : fire_a;
   // monitored bank divider writes as well
   assign load = wr & (hit(s.wa, `OFS_CTRL) | hit(s.wa, `OFS_PHASE) |
                 hit(s.wa, `OFS_CAL) |
                 (hit(s.wa, `OFS_DIVA) & ~s.ctrl[`B_STAT_SEL]) |
                 (hit(s.wa, `OFS_DIVB) & s.ctrl[`B_STAT_SEL]));

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      n = s;
      // Pins pass two flops before any use
      n.m1 = pwm_period_marker;
      n.m2 = s.m1;
      n.m3 = s.m2;
      n.t1 = conversion_trigger;
      n.t2 = s.t1;
      n.t3 = s.t2;
      n.d1 = pwm_double_update;
      n.d2 = s.d1;
      n.rd = ~s.rd;
      n.cnt_a = st_a[11:0];
      n.cnt_b = st_b[11:0];
      n.wp = acc & hwrite;
      n.wa = haddr[7:0];
      // Read data fetched in address phase so hrdata is a flop
      if (acc && !hwrite) begin
         n.hrdata = rd_word(s, haddr[7:0]);
      end
      if (wr) begin
         if (hit(s.wa, `OFS_CTRL)) begin
            n.ctrl = hwdata[15:0];
         end
         if (hit(s.wa, `OFS_PHASE)) begin
            n.phase = hwdata[6:0];
         end
         if (hit(s.wa, `OFS_CAL)) begin
            n.cal = hwdata[4:0];
         end
         if (hit(s.wa, `OFS_DIVA)) begin
            n.diva = hwdata[11:`DIV_LSB];
         end
         if (hit(s.wa, `OFS_DIVB)) begin
            n.divb = hwdata[11:`DIV_LSB];
         end
      end
      // Fresh write wins over a period tick
      if (load) begin
         n.settle = `SETTLE_PERIODS;
      end else if (mon_tick && s.settle != 3'h0) begin
         n.settle = s.settle - 3'h1;
      end
      // filter words kept as given, left-justified
      // sinc3 filter output latched per bank
      for (int i = 0; i < 5; i++) begin
         if ((i < 2) ? upd_a : upd_b) begin
            n.data[i] = filt_data[i];
         end
      end
      n.upd_a = upd_a;
      n.upd_b = upd_b;
      n.irq_a = upd_a & ~s.ctrl[`B_RD_A];
      n.irq_b = upd_b & ~s.ctrl[`B_RD_B];
      // bank A ranks above bank B
      n.vec = n.irq_a ? `VEC_A : n.irq_b ? `VEC_B : `VEC_NONE;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
         s.ctrl <= `CTRL_RST;
         s.phase <= `PHASE_RST;
         s.cal <= `CAL_RST;
         s.diva <= `DIV_RST;
         s.divb <= `DIV_RST;
         s.settle <= `SETTLE_PERIODS;
      end else begin
         s <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Zero wait states; no error responses exist
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s.hrdata;
   // bits 4 to 6 straight to pins
   assign expansion_select = s.ctrl[`B_MUX+2:`B_MUX];
   assign cal_tie_ref = s.cal;
   assign bank_a_update = s.upd_a;
   assign bank_b_update = s.upd_b;
   assign bank_a_irq = s.irq_a;
   assign bank_b_irq = s.irq_b;
   assign irq_vector = s.vec;

   ////////////////////////////////////////////////////////////////////
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   read_no_irq_a: assert property (
      s.ctrl[`B_RD_A] |=> !bank_a_irq)
      else $error("bank A irq in read mode");
   irq_has_upd_a: assert property (
      bank_a_irq |-> bank_a_update && irq_vector == `VEC_A)
      else $error("bank A irq without update");
   mux_write_a: assert property (
      wr && hit(s.wa, `OFS_CTRL)
      |=> expansion_select == $past(hwdata[6:4]))
      else $error("mux select not from control");
   cal_write_a: assert property (
      wr && hit(s.wa, `OFS_CAL) |=> cal_tie_ref == $past(hwdata[4:0]))
      else $error("calibration select wrong");
   settle_load_a: assert property (
      wr && hit(s.wa, `OFS_PHASE) |=> s.settle == 3'h4)
      else $error("settle not loaded on write");
   stat_read_a: assert property (
      acc && !hwrite && hit(haddr[7:0], `OFS_STAT)
      |=> hrdata[0] == $past(s.settle != 3'h0))
      else $error("status bit wrong");
   ext_trig_a: assert property (
      trig && s.ctrl[`B_EXT_A] && !s.ctrl[`B_RD_A] |=> bank_a_update)
      else $error("external trigger missed");
   sync_zero_a: assert property (
      marker && lagz && s.ctrl[`B_SYNC_A] && s.ctrl[3:0] == 4'h0
      |=> bank_a_update ##1 !bank_a_update)
      else $error("no update at period start");
   div_keep_a: assert property (
      wr && hit(s.wa, `OFS_DIVB) |=> s.divb == $past(hwdata[11:6]))
      else $error("divider field wrong");
   read_rate_b: assert property (
      s.ctrl[`B_RD_B] [*3] |-> bank_b_update != $past(bank_b_update))
      else $error("read mode not half rate");
endmodule

// File: pwm_timing_model.sv
// Behavioural PWM timing unit that sources the period marker
`timescale 1ns/10ps
module pwm_timing_model (
   input wire logic hclk, // Clock
   input wire logic hresetn, // Reset, low
   input wire logic double_mode, // Double update mode
   input wire logic [15:0] period, // Period in clocks
   output logic marker, // Period marker
   output logic double_update // Mode level
);
   int cnt;
   assign double_update = double_mode;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 0;
         marker <= 1'b0;
      end else begin
         cnt <= (cnt + 1 >= period) ? 0 : cnt + 1;
         marker <= cnt < 4 || (double_mode && cnt >= period / 2 &&
            cnt < period / 2 + 4);
      end
   end
endmodule

// File: testbench.sv
// Self-checking bench of the ADC sync control block
`timescale 1ns/10ps
`include "adc_sync_defines.svh"
module testbench;
   import adc_sync_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic trig = 1'b0;
   logic dbl = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [15:0] per = 16'h0180;
   sample_t filt [5];
   logic hreadyout, hresp, marker, dbl_lvl, upd_a, upd_b, irq_a, irq_b;
   logic [31:0] hrdata, q;
   logic [2:0] xsel;
   logic [4:0] tie;
   logic [15:0] vec;
   // Outputs as they stood before each rising edge; avoids edge races
   logic upd_a_q, upd_b_q, irq_a_q, irq_b_q, marker_q;
   logic [15:0] vec_q;
   logic [31:0] model [int];
   int fail_count = 0;
   int comparisons = 0;
   int cyc = 0;
   int seed = 11;
   int cfg [5][3] = '{'{384, 0, 0}, '{384, 96, 0}, '{384, 96, 1},
      '{1152, 0, 0}, '{1152, 32, 0}};

   adc_sync_ctrl i_adc_sync_ctrl (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .pwm_period_marker(marker), .pwm_double_update(dbl_lvl),
      .conversion_trigger(trig), .filt_data(filt), .expansion_select(xsel),
      .cal_tie_ref(tie), .bank_a_update(upd_a), .bank_b_update(upd_b),
      .bank_a_irq(irq_a), .bank_b_irq(irq_b), .irq_vector(vec));
   pwm_timing_model i_pwm_timing_model (.hclk(hclk), .hresetn(hresetn),
      .double_mode(dbl), .period(per), .marker(marker),
      .double_update(dbl_lvl));

   initial forever #2.5 hclk = ~hclk;
   always @(negedge hclk) begin
      upd_a_q <= upd_a;
      upd_b_q <= upd_b;
      irq_a_q <= irq_a;
      irq_b_q <= irq_b;
      marker_q <= marker;
      vec_q <= vec;
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 50000) begin
         fail_count++;
         conclude();
      end
   end
////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_rng(input int got, input int lo, input int hi);
      comparisons++;
      if (got < lo || got > hi) begin
         fail_count++;
         $display("[FAIL] %0t cycles %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask
   function automatic logic [31:0] msk(input logic [7:0] a);
      case (a)
         `OFS_CTRL: return 32'h0000FFFF;
         `OFS_PHASE: return 32'h0000007F;
         `OFS_CAL: return 32'h0000001F;
         `OFS_DIVA, `OFS_DIVB: return 32'h00000FC0;
         default: return 32'h0;
      endcase
   endfunction
   // Holds each phase until hready, then one idle cycle before the next
   task automatic bus(input logic wr, input logic [7:0] a, input int d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      @(posedge hclk);
   endtask
   task automatic wr(input logic [7:0] a, input int d);
      bus(1'b1, a, d);
      model[a] = d & msk(a);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 0);
      check(q, e);
   endtask
   task automatic wait_upd(input bit b, output int n);
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while ((b ? upd_b_q : upd_a_q) !== 1'b1 && n < 5000);
   endtask
   task automatic mark();
      while (marker_q !== 1'b0) @(posedge hclk);
      while (marker_q !== 1'b1) @(posedge hclk);
   endtask
   task automatic settle(input int p);
      int t0;
      t0 = cyc;
      do bus(1'b0, `OFS_STAT, 0); while (q[0] && cyc - t0 < 5000);
      check_rng(cyc - t0, 3 * p - 12, 4 * p + 12);
   endtask
////////////////////////////////////////////////////////////////////////////
   initial begin
      int n, lag, ph, a;
      for (int i = 0; i < 5; i++) filt[i] = $random(seed);
      model[`OFS_CTRL] = `CTRL_RST;
      model[`OFS_PHASE] = 0;
      model[`OFS_CAL] = 0;
      model[`OFS_DIVA] = `DIV_RST << `DIV_LSB;
      model[`OFS_DIVB] = `DIV_RST << `DIV_LSB;
      model[8'h3C] = 0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check({xsel, tie, vec}, 32'h0);
      rd(`OFS_STAT, 32'h1);
      foreach (model[k]) rd(8'(k), model[k]);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         wr(`OFS_CTRL, i << `B_MUX);
         check(32'(xsel), i);
      end
      wr(`OFS_PHASE, $random(seed));
      rd(`OFS_PHASE, model[`OFS_PHASE]);
      wr(`OFS_CAL, $random(seed));
      check(32'(tie), model[`OFS_CAL]);
      rd(`OFS_CAL, model[`OFS_CAL]);
      for (int k = 0; k < 2; k++) begin
         a = k ? `OFS_DIVB : `OFS_DIVA;
         wr(8'(a), ({$random(seed)} % 58 + 6) << 6 | $random(seed) & 63);
         rd(8'(a), model[a]);
         wr(8'(a), 32'h180);
      end
      $display("test registers done");
      wr(`OFS_CTRL, 0);
      rd(`OFS_STAT, 32'h1);
      settle(384);
      wr(`OFS_CTRL, 1 << `B_STAT_SEL);
      settle(384);
      wr(`OFS_DIVB, 32'h240);
      settle(576);
      wr(`OFS_DIVA, 32'h180);
      rd(`OFS_STAT, 32'h0);
      wr(`OFS_CAL, 0);
      rd(`OFS_STAT, 32'h1);
      settle(576);
      for (int i = 0; i < 5; i++) rd(`OFS_DATA + 4 * i, {filt[i], 16'h0});
      $display("test settle done");
      wr(`OFS_CTRL, 1 << `B_EXT_A);
      trig <= 1'b1;
      wait_upd(0, n);
      check_rng(n, 3, 4);
      check({irq_a_q, vec_q}, {1'b1, `VEC_A});
      trig <= 1'b0;
      wr(`OFS_CTRL, 1 << `B_RD_A | 1 << `B_RD_B);
      wait_upd(0, n);
      wait_upd(0, n);
      check_rng(n, 2, 2);
      lag = 0;
      repeat (400) begin
         @(posedge hclk);
         if (irq_a_q !== 1'b0 || irq_b_q !== 1'b0) lag++;
      end
      check_rng(lag, 0, 0);
      wr(`OFS_CTRL, 1 << `B_RD_A);
      wait_upd(1, n);
      check({irq_b_q, vec_q}, {1'b1, `VEC_B});
      $display("test trigger and read done");
      for (int i = 0; i < 5; i++) begin
         per <= 16'(cfg[i][0]);
         dbl <= cfg[i][2][0];
         ph = cfg[i][1];
         wr(`OFS_CTRL, 1 << `B_SYNC_A);
         wr(`OFS_PHASE, ph);
         lag = (ph == 0 || cfg[i][2]) ? 3 : 2 + ((128 - ph) * 6 >> 1);
         repeat (2) mark();
         wait_upd(0, n);
         check_rng(n, lag - 2, lag + 2);
         wait_upd(0, n);
         check_rng(n, cfg[i][2] ? 192 : 384, cfg[i][2] ? 192 : 384);
      end
      wr(`OFS_DIVB, 32'h180);
      per <= 16'h0180;
      dbl <= 1'b0;
      wr(`OFS_CTRL, 1 << `B_SYNC_B);
      wr(`OFS_PHASE, 0);
      repeat (2) mark();
      wait_upd(1, n);
      check_rng(n, 2, 4);
      $display("test sync done");
      conclude();
   end
endmodule
